//--- hw/pci_cell.sv
// One terminal: edge catch latch, scan flag, debounce and scan sample.
// Assumes level_i is already synchronised and scan_end_i is a clk pulse.
`timescale 1ns/1ps
module pci_cell #(
	parameter int FW = 8
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic level_i,
	input wire logic catch_en_i,
	input wire logic fall_i,
	input wire logic scan_end_i,
	input wire logic [FW-1:0] filt_len_i,
	output logic pend_o,
	output logic flag_o,
	output logic level_o
);

	// All cell state
	typedef struct packed {
		logic prev; // Level one cycle ago
		logic pend; // Edge caught this scan
		logic flag; // Caught flag for program
		logic filt; // Debounced level
		logic [FW-1:0] cnt; // Debounce run length
		logic samp; // Level sampled at scan end
	} pci_cell_st_t;

	pci_cell_st_t st; // Registered state
	pci_cell_st_t next_st; // Next state
	logic edge_hit; // Qualifying edge this cycle

	////////////////////////////////////////////////////////////////////////
	// Catch path works on the raw synchronised level, not the filter
	always_comb begin
		next_st = st;
		next_st.prev = level_i;
		edge_hit = catch_en_i && (fall_i ? (st.prev && !level_i)
			: (!st.prev && level_i));
		if (scan_end_i) begin
			next_st.flag = st.pend;
			next_st.pend = edge_hit;
		end else if (edge_hit) begin
			next_st.pend = 1'b1;
		end
		if (!catch_en_i) begin
			next_st.pend = 1'b0;
		end
		// Debounce for plain use only
		if (level_i == st.filt) begin
			next_st.cnt = '0;
		end else if (st.cnt >= filt_len_i) begin
			next_st.filt = level_i;
			next_st.cnt = '0;
		end else begin
			next_st.cnt = st.cnt + 1'b1;
		end
		if (scan_end_i) begin
			next_st.samp = st.filt;
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pend_o = st.pend;
	assign flag_o = st.flag;
	assign level_o = st.samp;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	AST_RISE_CAUGHT: assert property (
		(catch_en_i && !fall_i && !st.prev && level_i && !scan_end_i)
		|=> st.pend)
		else $error("rising edge not caught");
	AST_FALL_CAUGHT: assert property (
		(catch_en_i && fall_i && st.prev && !level_i && !scan_end_i)
		|=> st.pend)
		else $error("falling edge not caught");
	AST_LATCH_HOLD: assert property (
		(st.pend && catch_en_i && !scan_end_i) |=> st.pend)
		else $error("catch latch dropped inside scan");
	AST_FLAG_XFER: assert property (
		scan_end_i |=> (st.flag == $past(st.pend)))
		else $error("flag not loaded from latch");
	AST_FLAG_ONE_SCAN: assert property (
		!scan_end_i |=> $stable(st.flag))
		else $error("flag changed between scan ends");
	AST_NO_CATCH_OFF: assert property (
		!catch_en_i |=> !st.pend)
		else $error("latch set while catch disabled");
	AST_SAMPLE_HOLD: assert property (
		!scan_end_i |=> $stable(st.samp))
		else $error("plain sample moved mid scan");

	COV_CAUGHT: cover property (st.pend && scan_end_i ##1 st.flag);
	COV_IGNORED: cover property (st.pend && edge_hit && !scan_end_i);

endmodule

//--- hw/pci_pkg.sv
// Constants and types shared by the pulse catch input unit.
// Assumes one 20 MHz controller clock and a scan engine on the same clock.
//
// Functional notes
// - Pulses shorter than a scan are still caught
// - High pulse of five microseconds is caught
// - Low pulse of five microseconds is caught
// - Catch detection bypasses the debounce filter
// - Per group polarity selects rising or falling
// - Further edges ignored until next scan
// - Caught flag stands exactly one scan
// - One read-only caught flag per group
// - Six catch terminals, one flag each
// - Each group runs exactly one function
// - Auxiliary terminals are plain inputs only
// - Plain inputs sampled once at scan end
package pci_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int NUM_GROUPS = 6; // Catch capable groups
	localparam int NUM_AUX = 3; // Auxiliary plain-only terminals
	localparam int NUM_PINS = 9; // All terminals
	localparam int MODE_W = 3; // Function field width per group
	localparam int FILT_W = 8; // Debounce length width
	localparam int ADDR_W = 5; // Byte address width

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [4:0] ADDR_MODE = 5'h00; // Function per group
	localparam logic [4:0] ADDR_POL = 5'h04; // 1 = catch falling edge
	localparam logic [4:0] ADDR_FLAG = 5'h08; // Caught flags, read-only
	localparam logic [4:0] ADDR_LEVEL = 5'h0c; // Plain input states
	localparam logic [4:0] ADDR_FILT = 5'h10; // Debounce length
	localparam logic [4:0] ADDR_IRQ_STAT = 5'h14; // Sticky, write 1 clears
	localparam logic [4:0] ADDR_IRQ_MASK = 5'h18; // Interrupt enables

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [17:0] MODE_RST = 18'h00000;
	localparam logic [5:0] POL_RST = 6'h00;
	localparam logic [7:0] FILT_RST = 8'h00;
	localparam logic [5:0] MASK_RST = 6'h00;

	////////////////////////////////////////////////////////////////////////
	// Group functions, exactly one per group
	typedef enum logic [2:0] {
		PCI_FN_PLAIN = 3'h0,
		PCI_FN_HSC = 3'h1,
		PCI_FN_CATCH = 3'h2,
		PCI_FN_INTR = 3'h3,
		PCI_FN_FREQ = 3'h4
	} pci_fn_t;

	// Bus slave states, one-hot
	typedef enum logic [1:0] {
		PCI_BUS_IDLE = 2'b01,
		PCI_BUS_ACK = 2'b10
	} pci_bus_t;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_FREQ_HZ = 20000000;
	localparam int CLK_PERIOD_NS = 1000000000 / CLK_FREQ_HZ;
	localparam int MIN_PULSE_NS = 5000; // Least on or off width
	localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int SYNC_STAGES = 2; // Latency of pin synchroniser

endpackage

//--- hw/pci_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous pins.
// Assumes each bit is independent; no multi-bit coherency is implied.
`timescale 1ns/1ps
module pci_sync #(
	parameter int W = 9
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	// Both stages of the synchroniser
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pci_sync_st_t;

	pci_sync_st_t st; // Registered state
	pci_sync_st_t next_st; // Next state

	////////////////////////////////////////////////////////////////////////
	// First stage only feeds the second
	always_comb begin
		next_st = st;
		next_st.s1 = d_i;
		next_st.s2 = st.s1;
	end

	// State register
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q_o = st.s2;

endmodule

//--- hw/pci_top.sv
// Pulse catch input unit: six catch groups, three plain auxiliary pins,
// Avalon-MM register slave with waitrequest and one level interrupt.
// Assumes pins are asynchronous; scan_end_i is a one-cycle pulse on clk_i.
`timescale 1ns/1ps
module pci_top #(
	parameter int NG = pci_pkg::NUM_GROUPS,
	parameter int FW = pci_pkg::FILT_W
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic scan_end_i,
	input wire logic group1_pulse_pin_i,
	input wire logic group2_pulse_pin_i,
	input wire logic group3_pulse_pin_i,
	input wire logic group4_pulse_pin_i,
	input wire logic group5_pulse_pin_i,
	input wire logic group6_pulse_pin_i,
	input wire logic group1_aux_pin_i,
	input wire logic group3_aux_pin_i,
	input wire logic group5_aux_pin_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	output logic catch_flag_group1_o,
	output logic catch_flag_group2_o,
	output logic catch_flag_group3_o,
	output logic catch_flag_group4_o,
	output logic catch_flag_group5_o,
	output logic catch_flag_group6_o
);

	////////////////////////////////////////////////////////////////////////
	// Top state
	typedef struct packed {
		pci_pkg::pci_bus_t bus; // Bus slave state
		logic wait_n; // High while answering
		logic [31:0] rdata; // Read data register
		logic [17:0] mode; // Function per group
		logic [5:0] pol; // Edge polarity per group
		logic [7:0] filt; // Debounce length
		logic [5:0] irq_stat; // Sticky caught events
		logic [5:0] irq_mask; // Interrupt enables
		logic irq; // Interrupt output
	} pci_top_st_t;

	pci_top_st_t st; // Registered state
	pci_top_st_t next_st; // Next state

	logic [pci_pkg::NUM_PINS-1:0] pin_raw; // Asynchronous pins
	logic [pci_pkg::NUM_PINS-1:0] pin_sync; // Synchronised pins
	logic [pci_pkg::NUM_PINS-1:0] cell_pend; // Catch latches
	logic [pci_pkg::NUM_PINS-1:0] cell_flag; // Caught flags
	logic [pci_pkg::NUM_PINS-1:0] cell_level; // Scan-sampled levels
	logic [pci_pkg::NUM_PINS-1:0] catch_en; // Catch mode per cell
	logic [pci_pkg::NUM_PINS-1:0] fall_sel; // Polarity per cell
	logic [NG-1:0] plain_en; // Group in plain mode
	logic [NG-1:0] catch_evt; // Catch reaching a flag
	logic [8:0] level_view; // Readable levels
	logic [31:0] reg_rd; // Read mux output
	logic wr_take; // Write takes effect
	logic rd_req; // Read awaiting answer
	logic [31:0] wr_merged; // Write data merged by byte

	////////////////////////////////////////////////////////////////////////
	// Pin bundle: groups 1 to 6 in bits 0 to 5, aux pins of 1, 3, 5 above
	assign pin_raw = {group5_aux_pin_i, group3_aux_pin_i, group1_aux_pin_i,
		group6_pulse_pin_i, group5_pulse_pin_i, group4_pulse_pin_i,
		group3_pulse_pin_i, group2_pulse_pin_i, group1_pulse_pin_i};

	// Every pin passes two flip-flops before any logic
	pci_sync #(
		.W(pci_pkg::NUM_PINS)
	) u_sync (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.d_i(pin_raw),
		.q_o(pin_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// Function decode per group; only catch mode arms a cell
	always_comb begin
		catch_en = '0;
		fall_sel = '0;
		plain_en = '0;
		for (int g = 0; g < NG; g++) begin
			catch_en[g] = (st.mode[g*pci_pkg::MODE_W +: pci_pkg::MODE_W]
				== pci_pkg::PCI_FN_CATCH);
			plain_en[g] = (st.mode[g*pci_pkg::MODE_W +: pci_pkg::MODE_W]
				== pci_pkg::PCI_FN_PLAIN);
			fall_sel[g] = st.pol[g];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// One cell per terminal; aux cells never catch
	for (genvar i = 0; i < pci_pkg::NUM_PINS; i++) begin : g_cell
		pci_cell #(
			.FW(FW)
		) u_cell (
			.clk_i(clk_i),
			.arst_n_i(arst_n_i),
			.level_i(pin_sync[i]),
			.catch_en_i(catch_en[i]),
			.fall_i(fall_sel[i]),
			.scan_end_i(scan_end_i),
			.filt_len_i(st.filt),
			.pend_o(cell_pend[i]),
			.flag_o(cell_flag[i]),
			.level_o(cell_level[i])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Events and readable views
	always_comb begin
		// Latch moving into a flag at the scan end
		catch_evt = scan_end_i ? cell_pend[NG-1:0] : '0;
		// Group pins show only in plain mode, aux pins always
		level_view = {cell_level[8:6], cell_level[5:0] & plain_en};
	end

	// Master holds a request until waitrequest low is sampled
	assign rd_req = avs_read_i && (st.bus == pci_pkg::PCI_BUS_IDLE);
	assign wr_take = avs_write_i && (st.bus == pci_pkg::PCI_BUS_ACK);

	// Byte-lane merge of write data onto a zero-extended old value
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped offsets read zero
	always_comb begin
		reg_rd = '0;
		case (avs_address_i)
			pci_pkg::ADDR_MODE: begin
				reg_rd = {14'h0000, st.mode};
			end
			pci_pkg::ADDR_POL: begin
				reg_rd = {26'h0000000, st.pol};
			end
			pci_pkg::ADDR_FLAG: begin
				reg_rd = {26'h0000000, cell_flag[NG-1:0]};
			end
			pci_pkg::ADDR_LEVEL: begin
				reg_rd = {23'h000000, level_view};
			end
			pci_pkg::ADDR_FILT: begin
				reg_rd = {24'h000000, st.filt};
			end
			pci_pkg::ADDR_IRQ_STAT: begin
				reg_rd = {26'h0000000, st.irq_stat};
			end
			pci_pkg::ADDR_IRQ_MASK: begin
				reg_rd = {26'h0000000, st.irq_mask};
			end
			default: begin
				reg_rd = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Bus slave, registers and interrupt
	always_comb begin
		next_st = st;
		wr_merged = '0;
		case (st.bus)
			pci_pkg::PCI_BUS_IDLE: begin
				// Request seen: answer on the next edge
				if (avs_read_i || avs_write_i) begin
					next_st.bus = pci_pkg::PCI_BUS_ACK;
					next_st.wait_n = 1'b1;
					next_st.rdata = rd_req ? reg_rd : '0;
				end
			end
			pci_pkg::PCI_BUS_ACK: begin
				// Master takes the answer at this edge
				next_st.bus = pci_pkg::PCI_BUS_IDLE;
				next_st.wait_n = 1'b0;
			end
			default: begin
				next_st.bus = pci_pkg::PCI_BUS_IDLE;
				next_st.wait_n = 1'b0;
			end
		endcase
		// Register writes; flags and levels have no write path
		if (wr_take) begin
			case (avs_address_i)
				pci_pkg::ADDR_MODE: begin
					wr_merged = be_merge({14'h0000, st.mode},
						avs_writedata_i, avs_byteenable_i);
					next_st.mode = wr_merged[17:0];
				end
				pci_pkg::ADDR_POL: begin
					wr_merged = be_merge({26'h0000000, st.pol},
						avs_writedata_i, avs_byteenable_i);
					next_st.pol = wr_merged[5:0];
				end
				pci_pkg::ADDR_FILT: begin
					wr_merged = be_merge({24'h000000, st.filt},
						avs_writedata_i, avs_byteenable_i);
					next_st.filt = wr_merged[7:0];
				end
				pci_pkg::ADDR_IRQ_STAT: begin
					if (avs_byteenable_i[0]) begin
						next_st.irq_stat = st.irq_stat
							& ~avs_writedata_i[5:0];
					end
				end
				pci_pkg::ADDR_IRQ_MASK: begin
					wr_merged = be_merge({26'h0000000, st.irq_mask},
						avs_writedata_i, avs_byteenable_i);
					next_st.irq_mask = wr_merged[5:0];
				end
				default: begin
					wr_merged = '0;
				end
			endcase
		end
		// New events win over a clear in the same cycle
		next_st.irq_stat = next_st.irq_stat | catch_evt;
		next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
	end

	// State register
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st.bus <= pci_pkg::PCI_BUS_IDLE;
			st.wait_n <= 1'b0;
			st.rdata <= '0;
			st.mode <= pci_pkg::MODE_RST;
			st.pol <= pci_pkg::POL_RST;
			st.filt <= pci_pkg::FILT_RST;
			st.irq_stat <= '0;
			st.irq_mask <= pci_pkg::MASK_RST;
			st.irq <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all from flip-flops
	assign avs_readdata_o = st.rdata;
	assign avs_waitrequest_o = !st.wait_n;
	assign irq_o = st.irq;
	assign catch_flag_group1_o = cell_flag[0];
	assign catch_flag_group2_o = cell_flag[1];
	assign catch_flag_group3_o = cell_flag[2];
	assign catch_flag_group4_o = cell_flag[3];
	assign catch_flag_group5_o = cell_flag[4];
	assign catch_flag_group6_o = cell_flag[5];

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	// Pin rise reaches the catch latch after the synchroniser
	// Pin sampled at edge t, latch set at edge t+2, seen at edge t+3
	AST_SYNC_LAT: assert property (
		($rose(pin_raw[0]) && catch_en[0] && !st.pol[0])
		##1 (catch_en[0] && !st.pol[0]) [*2] |=> cell_pend[0])
		else $error("synchronised edge not latched in time");
	AST_READ_ONLY: assert property (
		(wr_take && avs_address_i == pci_pkg::ADDR_FLAG && !scan_end_i)
		|=> $stable(cell_flag[NG-1:0]))
		else $error("flag write changed a caught flag");
	AST_AUX_NO_FLAG: assert property (
		cell_flag[8:6] == 3'h0)
		else $error("aux terminal produced a flag");
	// Empty latch at a scan end drops the flag for the next scan
	AST_FLAG_EXACT: assert property (
		(scan_end_i && !cell_pend[0]) |=> !catch_flag_group1_o)
		else $error("flag stood beyond one scan");
	AST_BUS_ANSWER: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o
		|-> ##[1:2] !avs_waitrequest_o)
		else $error("slave did not answer");
	AST_IRQ_SET: assert property (
		(catch_evt[1] && st.irq_mask[1]) |=> irq_o)
		else $error("unmasked catch did not raise interrupt");

	COV_CATCH_RISE: cover property (catch_flag_group1_o && !st.pol[0]);
	COV_CATCH_FALL: cover property (catch_flag_group2_o && st.pol[1]);
	COV_IRQ: cover property (irq_o);

endmodule

//--- tb/pci_sensor.sv
// External sensor model driving the nine input terminals of the unit.
// Assumes the bench calls its tasks; levels change just after a clk rise.
`timescale 1ns/1ps
module pci_sensor (
	input wire logic clk_i,
	output logic [8:0] pins_o
);

	////////////////////////////////////////////////////////////////////////
	// Terminal levels: [5:0] catch groups, [8:6] auxiliary 1, 3, 5
	initial pins_o = 9'h000;

	// Hold one terminal at a steady level
	task automatic set_level(input int idx, input logic v);
		@(posedge clk_i);
		pins_o[idx] <= v;
	endtask

	// Swing away from the idle level for width cycles, then return
	task automatic pulse(input int idx, input int width);
		logic idle;
		// Read the level after the edge so a pending update is seen
		@(posedge clk_i);
		idle = pins_o[idx];
		pins_o[idx] <= ~idle;
		repeat (width) @(posedge clk_i);
		pins_o[idx] <= idle;
	endtask

endmodule

//--- tb/pulse_catch_input_unit_tb_top.sv
// Self-checking bench for the pulse catch input unit.
// Assumes the sensor model in pci_sensor and one 20 MHz clock.
`timescale 1ns/1ps
module pulse_catch_input_unit_tb_top;

	////////////////////////////////////////////////////////////////////////
	// Stimulus and observed signals
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic scan_end_i = 1'b0;
	logic [4:0] avs_address_i = 5'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h00000000;
	logic [3:0] avs_byteenable_i = 4'hf; // Whole words only
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic irq_o;
	logic [5:0] flags; // Caught flags, group 1 in bit 0
	logic [8:0] pins; // Terminal levels from the sensor model
	logic [31:0] rd; // Last read data
	logic [8:0] row;
	int error_cnt = 0;
	int cmp_count = 0;
	// Row: {group[8:6], mode[5:3], fall[2], final level[1], caught[0]}
	logic [8:0] rows [10] = '{9'h013, 9'h055, 9'h090, 9'h0d6, 9'h115,
		9'h153, 9'h002, 9'h04a, 9'h09a, 9'h0e2};

	// Free-running clock
	always #(pci_pkg::CLK_PERIOD_NS / 2) clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////
	// Design and far side
	pci_sensor sensor (.clk_i(clk_i), .pins_o(pins));

	pci_top uut (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .scan_end_i(scan_end_i),
		.group1_pulse_pin_i(pins[0]), .group2_pulse_pin_i(pins[1]),
		.group3_pulse_pin_i(pins[2]), .group4_pulse_pin_i(pins[3]),
		.group5_pulse_pin_i(pins[4]), .group6_pulse_pin_i(pins[5]),
		.group1_aux_pin_i(pins[6]), .group3_aux_pin_i(pins[7]),
		.group5_aux_pin_i(pins[8]), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
		.catch_flag_group1_o(flags[0]), .catch_flag_group2_o(flags[1]),
		.catch_flag_group3_o(flags[2]), .catch_flag_group4_o(flags[3]),
		.catch_flag_group5_o(flags[4]), .catch_flag_group6_o(flags[5])
	);

	////////////////////////////////////////////////////////////////////////
	// Verdict and comparisons
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Register word compare
	task automatic chk_word(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Flag vector compare
	task automatic chk_flags(input string nm, input logic [5:0] e);
		cmp_count++;
		if (flags !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, flags);
		end
	endtask

	// Single output compare
	task automatic chk_bit(input string nm, input logic e, input logic s);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %b seen %b", nm, e, s);
		end
	endtask

	// One bus transfer; held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		// A slave that never answers is left to the watchdog
		do begin
			@(posedge clk_i);
		end while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	// One scan boundary, then let the flags settle
	task automatic scan();
		@(posedge clk_i);
		scan_end_i <= 1'b1;
		@(posedge clk_i);
		scan_end_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		chk_bit("waitrequest", 1'b1, avs_waitrequest_o);
		chk_bit("irq", 1'b0, irq_o);
		chk_flags("reset flags", 6'h00);
		// Reset values of every offset, unmapped one included
		bus(1'b1, 5'h1c, 32'hffffffff);
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, 5'(i * 4), 32'h00000000);
			chk_word("reset read", 32'h00000000, rd);
		end
		// Table of modes, polarities and edge directions per group
		for (int r = 0; r < 10; r++) begin
			row = rows[r];
			bus(1'b1, pci_pkg::ADDR_MODE, 32'(row[5:3]) << (3 * row[8:6]));
			bus(1'b1, pci_pkg::ADDR_POL, 32'(row[2]) << row[8:6]);
			sensor.set_level(int'(row[8:6]), ~row[1]);
			repeat (10) @(posedge clk_i);
			scan();
			scan();
			sensor.set_level(int'(row[8:6]), row[1]);
			repeat (10) @(posedge clk_i);
			scan();
			chk_flags("row", row[0] ? 6'h01 << row[8:6] : 6'h00);
			scan();
			chk_flags("row next scan", 6'h00);
		end
		// Short high pulse with the longest debounce setting
		bus(1'b1, pci_pkg::ADDR_FILT, 32'h000000ff);
		bus(1'b1, pci_pkg::ADDR_MODE, 32'h00000010);
		bus(1'b1, pci_pkg::ADDR_POL, 32'h00000000);
		sensor.set_level(1, 1'b0);
		scan();
		scan();
		sensor.pulse(1, pci_pkg::MIN_PULSE_CYC);
		repeat (10) @(posedge clk_i);
		scan();
		chk_flags("high pulse", 6'h02);
		// Low pulses, two in one scan, falling polarity
		bus(1'b1, pci_pkg::ADDR_POL, 32'h00000002);
		sensor.set_level(1, 1'b1);
		scan();
		scan();
		bus(1'b1, pci_pkg::ADDR_IRQ_STAT, 32'h0000003f);
		sensor.pulse(1, pci_pkg::MIN_PULSE_CYC);
		sensor.pulse(1, pci_pkg::MIN_PULSE_CYC);
		repeat (10) @(posedge clk_i);
		scan();
		chk_flags("low pulse", 6'h02);
		bus(1'b1, pci_pkg::ADDR_FLAG, 32'h00000000);
		bus(1'b0, pci_pkg::ADDR_FLAG, 32'h00000000);
		chk_word("flag reg", 32'h00000002, rd);
		chk_flags("flag after write", 6'h02);
		// Interrupt: sticky status, mask, write one to clear
		bus(1'b0, pci_pkg::ADDR_IRQ_STAT, 32'h00000000);
		chk_word("irq stat", 32'h00000002, rd);
		chk_bit("irq masked", 1'b0, irq_o);
		bus(1'b1, pci_pkg::ADDR_IRQ_MASK, 32'h00000002);
		repeat (2) @(posedge clk_i);
		chk_bit("irq enabled", 1'b1, irq_o);
		bus(1'b1, pci_pkg::ADDR_IRQ_STAT, 32'h00000002);
		repeat (2) @(posedge clk_i);
		chk_bit("irq cleared", 1'b0, irq_o);
		bus(1'b0, pci_pkg::ADDR_IRQ_STAT, 32'h00000000);
		chk_word("irq stat cleared", 32'h00000000, rd);
		scan();
		chk_flags("second pulse ignored", 6'h00);
		// Auxiliary terminals: plain only, sampled at scan end
		bus(1'b1, pci_pkg::ADDR_MODE, 32'h00012492);
		bus(1'b1, pci_pkg::ADDR_POL, 32'h00000000);
		sensor.set_level(6, 1'b1);
		sensor.set_level(7, 1'b1);
		sensor.set_level(8, 1'b1);
		// Debounce is still at its longest setting: outlast it
		repeat (300) @(posedge clk_i);
		scan();
		chk_flags("aux no catch", 6'h00);
		bus(1'b0, pci_pkg::ADDR_LEVEL, 32'h00000000);
		chk_word("level", 32'h000001c0, rd);
		sensor.set_level(7, 1'b0);
		repeat (300) @(posedge clk_i);
		bus(1'b0, pci_pkg::ADDR_LEVEL, 32'h00000000);
		chk_word("level held", 32'h000001c0, rd);
		scan();
		bus(1'b0, pci_pkg::ADDR_LEVEL, 32'h00000000);
		chk_word("level resampled", 32'h00000140, rd);
		report_and_stop();
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (40000) @(posedge clk_i);
		error_cnt++;
		$display("MISMATCH watchdog expected done seen running");
		report_and_stop();
	end

endmodule
